// file: rtl/pmx_map.svh
// Constants for the port and memory expansion block
// Summary of operation
// - Port one per-bit direction, inputs on reset
// - Port two per-bit direction, inputs on reset
// - Control port per-bit, alternate roles, reset port-input
// - Control port alternate line mapping fixed
// - Serial clock out if internal, else input
// - Bus port direction set per whole byte
// - Bus port multiplexes low address and data
// - High port per-bit, drives address in 4K, 16K and 60K modes
// - Pulse latch enable to capture low address
// - Read strobe low while externals drive data
// - Write strobe low while write data valid
// - Expansion select pins sampled as mode inputs
// - Select pins output fetch marker, I/O flag
// - 64K space, internal ROM low, RAM top
// - External range at most 60K bytes
// - Reset low initialises all port state
// - Mode sets how many high bits are address
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH
`define PMX_ROM_TOP 16'h0fff
`define PMX_RAM_BASE 16'hff00
`define PMX_RESET_DIR 8'h00
`define PMX_RESET_OUT 8'h00
`define PMX_ALE_CYC 2'h1
`define PMX_STB_CYC 2'h2
`define PMX_SYNC_FILL 2'h2
`define PMX_ALT_TXD 0
`define PMX_ALT_RXD 1
`define PMX_ALT_SCK 2
`define PMX_ALT_TI 3
`define PMX_ALT_TO 4
`define PMX_ALT_CI 5
`define PMX_ALT_CO0 6
`define PMX_ALT_CO1 7
`endif

// file: rtl/pmx_pkg.sv
// Types for the port and memory expansion block
package pmx_pkg;
  // Expansion modes picked by the enable input and the two select pins
  typedef enum logic [2:0] {
    PMX_EXP_NONE, PMX_EXP_256, PMX_EXP_4K, PMX_EXP_16K, PMX_EXP_60K
  } pmx_mode_t;
  // Bus cycle phases
  typedef enum logic [1:0] {
    PMX_IDLE, PMX_ADDR, PMX_STROBE, PMX_HOLD
  } pmx_phase_t;
  // One request from the core side
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic io;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pmx_req_t;
  // One three-state pin group
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pmx_pins_t;
endpackage : pmx_pkg

// file: rtl/pmx_sync.sv
// Two flip-flop synchroniser for a byte of pin inputs
`timescale 1ns/1ps
module pmx_sync #(
  parameter int WIDTH = 8
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // First stage is read by the second stage only
  logic [WIDTH-1:0] meta;
  // Both stages clear to zero under reset
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pmx_sync

// file: rtl/pmx_port.sv
// One general port with per-bit direction and a role override
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_port (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [7:0] dir_out,
  input wire logic [7:0] out_val,
  input wire logic [7:0] role_mask,
  input wire logic [7:0] role_out,
  input wire logic [7:0] role_oe,
  output pmx_pkg::pmx_pins_t pins
);
  // Registered pin drive; reset makes every line an input
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pins.out <= `PMX_RESET_OUT;
      pins.oe <= `PMX_RESET_DIR;
    end else begin
      // Overridden bits follow their role, not the direction bit
      pins.out <= (role_mask & role_out) | (~role_mask & out_val);
      pins.oe <= (role_mask & role_oe) | (~role_mask & dir_out);
    end
  end
endmodule : pmx_port

// file: rtl/pmx_expansion.sv
// Port and memory expansion interface top
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_expansion (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Core port settings
  input wire logic [7:0] GEN_ONE_DIR,
  input wire logic [7:0] GEN_ONE_OUT,
  input wire logic [7:0] GEN_TWO_DIR,
  input wire logic [7:0] GEN_TWO_OUT,
  input wire logic [7:0] CTL_DIR,
  input wire logic [7:0] CTL_OUT,
  input wire logic [7:0] CTL_ALT_SEL,
  input wire logic BUS_DIR_OUT,
  input wire logic [7:0] BUS_OUT,
  input wire logic [7:0] HIGH_DIR,
  input wire logic [7:0] HIGH_OUT,
  input wire logic EXP_ENABLE,
  // Alternate function sources from serial and timers
  input wire logic SER_TXD,
  input wire logic SER_CLK_INT,
  input wire logic SER_CLK_OUT,
  input wire logic TMR_SQUARE,
  input wire logic CNT_WAVE_ZERO,
  input wire logic CNT_WAVE_ONE,
  // Core bus request
  input pmx_pkg::pmx_req_t REQ,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic REQ_INTERNAL,
  output logic [2:0] EXP_MODE,
  // Pins, each as in, out and enable; strobes and latch enable are out only
  input wire logic [7:0] GENERAL_PORT_ONE_LINES_I,
  output logic [7:0] GENERAL_PORT_ONE_LINES_O,
  output logic [7:0] GENERAL_PORT_ONE_LINES_OE,
  input wire logic [7:0] GENERAL_PORT_TWO_LINES_I,
  output logic [7:0] GENERAL_PORT_TWO_LINES_O,
  output logic [7:0] GENERAL_PORT_TWO_LINES_OE,
  input wire logic [7:0] CONTROL_PORT_LINES_I,
  output logic [7:0] CONTROL_PORT_LINES_O,
  output logic [7:0] CONTROL_PORT_LINES_OE,
  input wire logic [7:0] BUS_PORT_LINES_I,
  output logic [7:0] BUS_PORT_LINES_O,
  output logic [7:0] BUS_PORT_LINES_OE,
  input wire logic [7:0] HIGH_ADDRESS_PORT_LINES_I,
  output logic [7:0] HIGH_ADDRESS_PORT_LINES_O,
  output logic [7:0] HIGH_ADDRESS_PORT_LINES_OE,
  input wire logic EXPANSION_SELECT_ONE_I,
  output logic EXPANSION_SELECT_ONE_O,
  output logic EXPANSION_SELECT_ONE_OE,
  input wire logic EXPANSION_SELECT_ZERO_I,
  output logic EXPANSION_SELECT_ZERO_O,
  output logic EXPANSION_SELECT_ZERO_OE,
  output logic READ_STROBE_N,
  output logic WRITE_STROBE_N,
  output logic ADDR_LATCH_EN,
  // Synchronised pin levels for the core
  output logic [7:0] GEN_ONE_IN,
  output logic [7:0] GEN_TWO_IN,
  output logic [7:0] CTL_IN,
  output logic [7:0] BUS_IN,
  output logic [7:0] HIGH_IN,
  output logic SER_RXD,
  output logic SER_CLK_EXT,
  output logic TIMER_CLOCK_PIN,
  output logic EDGE_REQUEST_TWO,
  output logic EVENT_COUNT_INPUT
);
  // Sequencer and strap state of the block
  typedef struct packed {
    pmx_pkg::pmx_phase_t phase;
    logic [1:0] cnt;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic fetch;
    logic io;
    logic rd_valid;
    logic [7:0] rd_data;
    logic strap_taken;
    logic [1:0] strap_wait;
    logic [1:0] sel;
  } pmx_state_t;

  pmx_state_t st;
  pmx_state_t next_st;
  logic [7:0] sel_sync;
  logic [7:0] sel_raw;
  logic [7:0] bus_in_s;
  logic [7:0] ctl_in_s;
  pmx_pkg::pmx_mode_t mode;
  logic [7:0] addr_mask;
  logic [7:0] ctl_role_oe;
  logic [7:0] ctl_role_out;
  logic bus_active;
  logic is_internal;
  pmx_pkg::pmx_pins_t p_one;
  pmx_pkg::pmx_pins_t p_two;
  pmx_pkg::pmx_pins_t p_ctl;
  pmx_pkg::pmx_pins_t p_high;

  // Select pins go through the synchroniser like any pin
  assign sel_raw = {6'h00, EXPANSION_SELECT_ONE_I, EXPANSION_SELECT_ZERO_I};

  // Synchronisers for every input pin group
  pmx_sync #(.WIDTH(8)) u_sync_one (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(GENERAL_PORT_ONE_LINES_I), .q(GEN_ONE_IN));
  pmx_sync #(.WIDTH(8)) u_sync_two (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(GENERAL_PORT_TWO_LINES_I), .q(GEN_TWO_IN));
  pmx_sync #(.WIDTH(8)) u_sync_ctl (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(CONTROL_PORT_LINES_I), .q(ctl_in_s));
  pmx_sync #(.WIDTH(8)) u_sync_bus (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(BUS_PORT_LINES_I), .q(bus_in_s));
  pmx_sync #(.WIDTH(8)) u_sync_high (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(HIGH_ADDRESS_PORT_LINES_I), .q(HIGH_IN));
  pmx_sync #(.WIDTH(8)) u_sync_sel (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .d(sel_raw), .q(sel_sync));

  // Decode a select pair into an expansion mode
  function automatic pmx_pkg::pmx_mode_t sel_to_mode(input logic en,
                                                     input logic [1:0] s);
    if (!en)
      return pmx_pkg::PMX_EXP_NONE;
    case (s)
      2'h0: return pmx_pkg::PMX_EXP_4K;
      2'h1: return pmx_pkg::PMX_EXP_16K;
      2'h2: return pmx_pkg::PMX_EXP_256;
      default: return pmx_pkg::PMX_EXP_60K;
    endcase
  endfunction : sel_to_mode

  // High port bits that carry address in each mode
  function automatic logic [7:0] mode_mask(input pmx_pkg::pmx_mode_t m);
    case (m)
      pmx_pkg::PMX_EXP_4K: return 8'h0f;
      pmx_pkg::PMX_EXP_16K: return 8'h3f;
      pmx_pkg::PMX_EXP_60K: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction : mode_mask

  assign mode = sel_to_mode(EXP_ENABLE, st.sel);
  assign addr_mask = mode_mask(mode);
  assign bus_active = (mode != pmx_pkg::PMX_EXP_NONE);
  // Internal ROM at the bottom, RAM at the top; the rest is external
  assign is_internal = (REQ.addr <= `PMX_ROM_TOP) ||
                       (REQ.addr >= `PMX_RAM_BASE);

  // Control port alternate drive: serial clock only when internal
  always_comb begin
    ctl_role_oe = 8'h00;
    ctl_role_out = 8'h00;
    ctl_role_oe[`PMX_ALT_TXD] = 1'b1;
    ctl_role_out[`PMX_ALT_TXD] = SER_TXD;
    ctl_role_oe[`PMX_ALT_SCK] = SER_CLK_INT;
    ctl_role_out[`PMX_ALT_SCK] = SER_CLK_OUT;
    ctl_role_oe[`PMX_ALT_TO] = 1'b1;
    ctl_role_out[`PMX_ALT_TO] = TMR_SQUARE;
    ctl_role_oe[`PMX_ALT_CO0] = 1'b1;
    ctl_role_out[`PMX_ALT_CO0] = CNT_WAVE_ZERO;
    ctl_role_oe[`PMX_ALT_CO1] = 1'b1;
    ctl_role_out[`PMX_ALT_CO1] = CNT_WAVE_ONE;
  end

  // General ports have no alternate role
  pmx_port u_one (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .dir_out(GEN_ONE_DIR),
    .out_val(GEN_ONE_OUT), .role_mask(8'h00), .role_out(8'h00),
    .role_oe(8'h00), .pins(p_one));
  pmx_port u_two (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .dir_out(GEN_TWO_DIR),
    .out_val(GEN_TWO_OUT), .role_mask(8'h00), .role_out(8'h00),
    .role_oe(8'h00), .pins(p_two));
  pmx_port u_ctl (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .dir_out(CTL_DIR),
    .out_val(CTL_OUT), .role_mask(CTL_ALT_SEL), .role_out(ctl_role_out),
    .role_oe(ctl_role_oe), .pins(p_ctl));
  // High port address bits are forced outputs; the next address is used
  // so the pin flop loads with the cycle and stands with the latch pulse
  pmx_port u_high (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .dir_out(HIGH_DIR),
    .out_val(HIGH_OUT), .role_mask(addr_mask), .role_out(next_st.addr[15:8]),
    .role_oe(8'hff), .pins(p_high));

  assign GENERAL_PORT_ONE_LINES_O = p_one.out;
  assign GENERAL_PORT_ONE_LINES_OE = p_one.oe;
  assign GENERAL_PORT_TWO_LINES_O = p_two.out;
  assign GENERAL_PORT_TWO_LINES_OE = p_two.oe;
  assign CONTROL_PORT_LINES_O = p_ctl.out;
  assign CONTROL_PORT_LINES_OE = p_ctl.oe;
  assign HIGH_ADDRESS_PORT_LINES_O = p_high.out;
  assign HIGH_ADDRESS_PORT_LINES_OE = p_high.oe;

  // Alternate inputs come from the synchronised control port
  assign CTL_IN = ctl_in_s;
  assign SER_RXD = ctl_in_s[`PMX_ALT_RXD];
  assign SER_CLK_EXT = ctl_in_s[`PMX_ALT_SCK];
  assign TIMER_CLOCK_PIN = ctl_in_s[`PMX_ALT_TI];
  assign EDGE_REQUEST_TWO = ctl_in_s[`PMX_ALT_TI];
  assign EVENT_COUNT_INPUT = ctl_in_s[`PMX_ALT_CI];
  assign BUS_IN = bus_in_s;

  // Bus cycle sequencer
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    // Strap taken once the cleared synchroniser has refilled after reset
    if (!st.strap_taken) begin
      if (st.strap_wait == `PMX_SYNC_FILL) begin
        next_st.sel = sel_sync[1:0];
        next_st.strap_taken = 1'b1;
      end else begin
        next_st.strap_wait = st.strap_wait + 2'h1;
      end
    end
    case (st.phase)
      pmx_pkg::PMX_IDLE: begin
        if (REQ.valid && bus_active && st.strap_taken && !is_internal) begin
          next_st.phase = pmx_pkg::PMX_ADDR;
          next_st.cnt = `PMX_ALE_CYC;
          next_st.write = REQ.write;
          next_st.addr = REQ.addr;
          next_st.wdata = REQ.wdata;
          next_st.fetch = REQ.fetch & ~REQ.write;
          next_st.io = REQ.io;
          next_st.ale = 1'b1;
        end
      end
      pmx_pkg::PMX_ADDR: begin
        next_st.cnt = st.cnt - 2'h1;
        if (st.cnt == 2'h1) begin
          next_st.ale = 1'b0;
          next_st.phase = pmx_pkg::PMX_STROBE;
          next_st.cnt = `PMX_STB_CYC;
          next_st.rd_n = st.write;
          next_st.wr_n = ~st.write;
        end
      end
      pmx_pkg::PMX_STROBE: begin
        next_st.cnt = st.cnt - 2'h1;
        if (st.cnt == 2'h1) begin
          // Strobes rise; read data is taken one cycle later
          next_st.rd_n = 1'b1;
          next_st.wr_n = 1'b1;
          next_st.phase = pmx_pkg::PMX_HOLD;
        end
      end
      pmx_pkg::PMX_HOLD: begin
        // One turnaround cycle so data holds past the strobe edge
        next_st.phase = pmx_pkg::PMX_IDLE;
        // Synchroniser output now shows the bus as sampled mid-strobe
        next_st.rd_valid = ~st.write;
        next_st.rd_data = bus_in_s;
        next_st.fetch = 1'b0;
        next_st.io = 1'b0;
      end
      default: next_st.phase = pmx_pkg::PMX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.phase <= pmx_pkg::PMX_IDLE;
      st.rd_n <= 1'b1;
      st.wr_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Registered bus port and status pin drive
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      BUS_PORT_LINES_O <= `PMX_RESET_OUT;
      BUS_PORT_LINES_OE <= `PMX_RESET_DIR;
      EXPANSION_SELECT_ONE_O <= 1'b0;
      EXPANSION_SELECT_ONE_OE <= 1'b0;
      EXPANSION_SELECT_ZERO_O <= 1'b0;
      EXPANSION_SELECT_ZERO_OE <= 1'b0;
      REQ_READY <= 1'b0;
      REQ_INTERNAL <= 1'b0;
      EXP_MODE <= 3'h0;
    end else begin
      if (bus_active && next_st.phase == pmx_pkg::PMX_ADDR) begin
        BUS_PORT_LINES_O <= next_st.addr[7:0];
        BUS_PORT_LINES_OE <= 8'hff;
      end else if (bus_active && next_st.phase != pmx_pkg::PMX_IDLE) begin
        BUS_PORT_LINES_O <= st.wdata;
        BUS_PORT_LINES_OE <= {8{st.write}};
      end else if (bus_active) begin
        BUS_PORT_LINES_O <= 8'h00;
        BUS_PORT_LINES_OE <= 8'h00;
      end else begin
        BUS_PORT_LINES_O <= BUS_OUT;
        BUS_PORT_LINES_OE <= {8{BUS_DIR_OUT}};
      end
      // Status pins drive only once the strap has been taken
      EXPANSION_SELECT_ONE_O <= next_st.fetch;
      EXPANSION_SELECT_ONE_OE <= st.strap_taken & bus_active;
      EXPANSION_SELECT_ZERO_O <= next_st.io;
      EXPANSION_SELECT_ZERO_OE <= st.strap_taken & bus_active;
      REQ_READY <= (next_st.phase == pmx_pkg::PMX_IDLE) & next_st.strap_taken;
      REQ_INTERNAL <= REQ.valid & is_internal;
      EXP_MODE <= 3'(mode);
    end
  end

  assign READ_STROBE_N = st.rd_n;
  assign WRITE_STROBE_N = st.wr_n;
  assign ADDR_LATCH_EN = st.ale;
  assign RD_VALID = st.rd_valid;
  assign RD_DATA = st.rd_data;

  // Checks
  a_strobe_excl: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !(!st.rd_n && !st.wr_n)) else $error("both strobes low");
  a_ale_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $rose(st.ale) |=> !st.ale ##0 (!st.rd_n || !st.wr_n))
    else $error("strobe does not follow latch pulse");
  a_rd_release: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !st.rd_n |-> BUS_PORT_LINES_OE == 8'h00)
    else $error("bus driven during read");
  a_wr_data: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !st.wr_n |-> BUS_PORT_LINES_OE == 8'hff && BUS_PORT_LINES_O == st.wdata)
    else $error("write data not on bus");
  a_ale_addr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st.ale |-> BUS_PORT_LINES_O == st.addr[7:0] && BUS_PORT_LINES_OE == 8'hff)
    else $error("low address missing at latch");
  a_high_addr: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    ##1 st.ale |-> ((HIGH_ADDRESS_PORT_LINES_OE & $past(addr_mask))
      == $past(addr_mask))) else $error("high address not driven");
  a_strobe_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $fell(st.rd_n) |-> !st.rd_n [*2] ##1 st.rd_n)
    else $error("read strobe length wrong");
  a_no_int_cycle: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st.phase == pmx_pkg::PMX_IDLE && REQ.valid && is_internal
      |=> !st.ale) else $error("internal address went external");
  a_bus_byte: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_PORT_LINES_OE == 8'h00 || BUS_PORT_LINES_OE == 8'hff)
    else $error("bus port split direction");
  c_read: cover property (@(posedge SYS_CLK) $fell(st.rd_n));
  c_write: cover property (@(posedge SYS_CLK) $fell(st.wr_n));
  c_fetch: cover property (@(posedge SYS_CLK) EXPANSION_SELECT_ONE_O);
endmodule : pmx_expansion

// file: sim/pmx_mem_model.sv
// Address latch and byte memory on the far side of the expansion bus
`timescale 1ns/1ps
module pmx_mem_model (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] bus_o,
  input wire logic [7:0] high_o,
  input wire logic [7:0] high_mask,
  output logic [7:0] bus_drv,
  output logic bus_en
);
  // Address held by the latch between cycles
  logic [15:0] lat_addr;
  // Storage; a cell never written reads unknown, so only read back writes
  logic [7:0] mem [0:65535];
  // Latch grabs the low byte while the pulse is high, memory takes writes
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lat_addr <= 16'h0000;
    end else if (ale) begin
      lat_addr <= {high_o & high_mask, bus_o};
    end else if (!wr_n) begin
      mem[lat_addr] <= bus_o;
    end
  end
  // Bus is driven only while the read strobe is low
  assign bus_en = !rd_n;
  assign bus_drv = mem[lat_addr];
endmodule : pmx_mem_model

// file: sim/pmx_expansion_tb_top.sv
// Self-checking bench for the port and memory expansion block
`timescale 1ns/1ps
module pmx_expansion_tb_top;
  logic SYS_CLK, RST_N, b_dir, exp_en, rdy, rdv, intl, m_en, ale, rd_n, wr_n;
  logic s1_i, s1_o, s1_oe, s0_i, s0_o, s0_oe;
  logic [1:0] strap; // Levels strapped on the select pins
  logic [5:0] per; // Peripheral sources for the alternate roles
  logic [7:0] g1_dir, g1_out, g2_dir, g2_out, c_dir, c_out, c_alt, b_out;
  logic [7:0] h_dir, h_out, msk, ext, m_drv, b_last, rdata;
  logic [7:0] g1_i, g1_o, g1_oe, g2_i, g2_o, g2_oe, c_i, c_o, c_oe;
  logic [7:0] b_i, b_o, b_oe, h_i, h_o, h_oe, g1_in, c_in;
  logic [7:0] g2_in, b_in, h_in;
  logic [4:0] alt_in; // rxd, sck in, timer pin, edge two, event count
  logic [2:0] mode_o;
  pmx_pkg::pmx_req_t req;
  int n_mismatch = 0;
  int n_tests = 0;
  // Pins resolve from every party's enable; an idle bus does not hold
  assign g1_i = (g1_oe & g1_o) | (~g1_oe & ext);
  assign g2_i = (g2_oe & g2_o) | (~g2_oe & ext);
  assign c_i = (c_oe & c_o) | (~c_oe & ext);
  assign h_i = (h_oe & h_o) | (~h_oe & ext);
  assign b_i = (b_oe & b_o) | (~b_oe & (m_en ? m_drv : ~b_last));
  assign s1_i = s1_oe ? s1_o : strap[1];
  assign s0_i = s0_oe ? s0_o : strap[0];
  always @(posedge SYS_CLK) b_last <= b_i;
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  pmx_expansion u_pmx_expansion (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .GEN_ONE_DIR(g1_dir), .GEN_ONE_OUT(g1_out), .GEN_TWO_DIR(g2_dir),
    .GEN_TWO_OUT(g2_out), .CTL_DIR(c_dir), .CTL_OUT(c_out),
    .CTL_ALT_SEL(c_alt), .BUS_DIR_OUT(b_dir), .BUS_OUT(b_out),
    .HIGH_DIR(h_dir), .HIGH_OUT(h_out), .EXP_ENABLE(exp_en),
    .SER_TXD(per[0]), .SER_CLK_INT(per[1]), .SER_CLK_OUT(per[2]),
    .TMR_SQUARE(per[3]), .CNT_WAVE_ZERO(per[4]), .CNT_WAVE_ONE(per[5]),
    .REQ(req), .REQ_READY(rdy), .RD_VALID(rdv), .RD_DATA(rdata),
    .REQ_INTERNAL(intl), .EXP_MODE(mode_o),
    .GENERAL_PORT_ONE_LINES_I(g1_i), .GENERAL_PORT_ONE_LINES_O(g1_o),
    .GENERAL_PORT_ONE_LINES_OE(g1_oe), .GENERAL_PORT_TWO_LINES_I(g2_i),
    .GENERAL_PORT_TWO_LINES_O(g2_o), .GENERAL_PORT_TWO_LINES_OE(g2_oe),
    .CONTROL_PORT_LINES_I(c_i), .CONTROL_PORT_LINES_O(c_o),
    .CONTROL_PORT_LINES_OE(c_oe), .BUS_PORT_LINES_I(b_i),
    .BUS_PORT_LINES_O(b_o), .BUS_PORT_LINES_OE(b_oe),
    .HIGH_ADDRESS_PORT_LINES_I(h_i), .HIGH_ADDRESS_PORT_LINES_O(h_o),
    .HIGH_ADDRESS_PORT_LINES_OE(h_oe), .EXPANSION_SELECT_ONE_I(s1_i),
    .EXPANSION_SELECT_ONE_O(s1_o), .EXPANSION_SELECT_ONE_OE(s1_oe),
    .EXPANSION_SELECT_ZERO_I(s0_i), .EXPANSION_SELECT_ZERO_O(s0_o),
    .EXPANSION_SELECT_ZERO_OE(s0_oe), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .ADDR_LATCH_EN(ale), .GEN_ONE_IN(g1_in),
    .GEN_TWO_IN(g2_in), .CTL_IN(c_in), .BUS_IN(b_in), .HIGH_IN(h_in),
    .SER_RXD(alt_in[4]), .SER_CLK_EXT(alt_in[3]),
    .TIMER_CLOCK_PIN(alt_in[2]), .EDGE_REQUEST_TWO(alt_in[1]),
    .EVENT_COUNT_INPUT(alt_in[0]));
  pmx_mem_model u_pmx_mem_model (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bus_o(b_o), .high_o(h_o),
    .high_mask(msk), .bus_drv(m_drv), .bus_en(m_en));
  // One comparison, counted, reported at once on a miss
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run, shared with the watchdog
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // Reset with the straps set; straps stay put well past the sample edge
  task automatic do_reset(input logic [1:0] s);
    RST_N <= 1'b0;
    strap <= s;
    repeat (9) @(posedge SYS_CLK);
    #1;
    check({g1_oe, g2_oe}, 16'h0000);
    check({c_oe, h_oe}, 16'h0000);
    check({5'h00, b_oe, rd_n, wr_n, ale}, 16'h0006);
    @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
  endtask : do_reset
  // One external transfer, watched cycle by cycle until idle again
  task automatic bus_cycle(input logic wr, input logic fe, input logic io,
      input logic [15:0] a, input logic [7:0] d);
    int k, ale_n, ale_at, st_n, st_at, oth_n, rv_n;
    k = 0;
    ale_n = 0;
    ale_at = 0;
    st_n = 0;
    st_at = 0;
    oth_n = 0;
    rv_n = 0;
    @(posedge SYS_CLK);
    req <= '{1'b1, wr, fe, io, a, d};
    @(posedge SYS_CLK);
    while (rdy !== 1'b1 && k < 20) begin
      @(posedge SYS_CLK);
      k++;
    end
    req.valid <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      #1;
      if (ale === 1'b1) begin
        ale_n++;
        ale_at = c;
        check({b_oe, b_o}, {8'hff, a[7:0]});
        check({h_oe, h_o}, {8'hff, a[15:8] & msk});
        check({s1_oe, s1_o, s0_oe, s0_o}, {1'b1, fe, 1'b1, io});
      end
      if ((wr ? wr_n : rd_n) === 1'b0) begin
        st_n++;
        st_at = (st_n == 1) ? c : st_at;
        check({b_oe, b_o & b_oe}, wr ? {8'hff, d} : 16'h0000);
      end
      oth_n += int'((wr ? rd_n : wr_n) === 1'b0);
      if (rdv === 1'b1) begin
        rv_n++;
        check({8'h00, rdata}, {8'h00, d});
      end
      @(posedge SYS_CLK);
    end
    check({4'(ale_n), 4'(st_n), 4'(oth_n), 4'(rv_n)}, {12'h120, 3'h0, !wr});
    check(16'(st_at - ale_at), 16'h0001);
  endtask : bus_cycle
  // Hang guard: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    logic [7:0] masks [4] = '{8'h0f, 8'h3f, 8'h00, 8'hff};
    logic [15:0] adrs [4] = '{16'h1234, 16'h3c5a, 16'h20a5, 16'hfe77};
    pmx_pkg::pmx_mode_t modes [4] = '{pmx_pkg::PMX_EXP_4K,
      pmx_pkg::PMX_EXP_16K, pmx_pkg::PMX_EXP_256, pmx_pkg::PMX_EXP_60K};
    int k;
    logic seen;
    {g1_dir, g1_out, g2_dir, g2_out, c_dir, c_out, c_alt} = '0;
    {b_dir, b_out, h_dir, h_out, exp_en, per, msk} = '0;
    req = '0;
    ext = 8'hc3;
    strap = 2'b11;
    RST_N = 1'b0;
    do_reset(2'b11);
    // Plain ports: per-bit direction and latched outputs
    g1_dir <= 8'ha5;
    g1_out <= 8'h3c;
    g2_dir <= 8'h5a;
    g2_out <= 8'hf0;
    c_dir <= 8'h0f;
    c_out <= 8'h99;
    h_dir <= 8'hc3;
    h_out <= 8'h81;
    b_dir <= 1'b1;
    b_out <= 8'h5a;
    repeat (4) @(posedge SYS_CLK);
    #1;
    check({g1_oe, g1_o & g1_oe}, 16'ha524);
    check(g1_in, (8'ha5 & 8'h3c) | (~8'ha5 & ext));
    check({g2_oe, g2_o & g2_oe}, 16'h5a50);
    check({c_oe, c_o & c_oe}, 16'h0f09);
    check({h_oe, h_o & h_oe}, 16'hc381);
    check({b_oe, b_o}, 16'hff5a);
    check({g2_in, h_in}, 16'hd181);
    check({8'h00, b_in}, 16'h005a);
    @(posedge SYS_CLK);
    b_dir <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1;
    check({8'h00, b_oe}, 16'h0000);
    $display("test ports done");
    // Alternate roles: txd, sck, square, counter outs drive
    c_alt <= 8'hff;
    c_dir <= 8'hff;
    c_out <= 8'h00;
    per <= 6'b101111;
    repeat (4) @(posedge SYS_CLK);
    #1;
    check({c_oe, c_o & c_oe}, 16'hd595);
    check({alt_in[4], alt_in[2:0]}, {ext[1], ext[3], ext[3], ext[5]});
    @(posedge SYS_CLK);
    per[1] <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    #1;
    check({c_oe, 7'h00, alt_in[3]}, {8'hd1, 7'h00, ext[2]});
    @(posedge SYS_CLK);
    c_alt <= 8'h00;
    $display("test alternate done");
    // Every strap mode: write, read back, internal address refused
    exp_en <= 1'b1;
    h_dir <= 8'hff;
    h_out <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      msk <= masks[i];
      do_reset(2'(i));
      #1;
      check({13'h0, mode_o}, {13'h0, 3'(modes[i])});
      bus_cycle(1'b1, 1'b0, 1'b1, adrs[i], adrs[i][7:0] ^ 8'h96);
      bus_cycle(1'b0, 1'b1, 1'b0, adrs[i], adrs[i][7:0] ^ 8'h96);
      @(posedge SYS_CLK);
      req <= '{1'b1, 1'b0, 1'b0, 1'b0, i[0] ? 16'hff10 : 16'h0800, 8'h00};
      k = 0;
      seen = 1'b0;
      repeat (8) begin
        @(posedge SYS_CLK);
        #1;
        k += int'(ale === 1'b1);
        seen = seen | (intl === 1'b1);
      end
      @(posedge SYS_CLK);
      req.valid <= 1'b0;
      check({15'h0, seen}, 16'h0001);
      check(16'(k), 16'h0000);
      $display("test mode %0d done", i);
    end
    stop_test();
  end
endmodule : pmx_expansion_tb_top
